// [src/ptb_pkg.sv]
/*
  package for the program-counter trace buffer control block: register
  offsets, field positions, reset values and the carrier structs.
  assumes an apb slave port on a 32-bit data bus and one system clock.
*/
`default_nettype none

package ptb_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  // printed offsets are not all multiples of four, so they are indexes
  localparam logic [23:0] CTRL_INDEX = 24'hffe013;
  localparam logic [23:0] PTR_INDEX = 24'hffe014;
  localparam logic [25:0] CTRL_ADDR = {CTRL_INDEX, 2'h0};
  localparam logic [25:0] PTR_ADDR = {PTR_INDEX, 2'h0};
  localparam int ADDR_W = 26;

  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int CTRL_ON_BIT = 7;
  localparam int CTRL_SEL_LSB = 0;
  localparam int SEL_W = 3;
  localparam int PTR_W = 24;
  localparam int PTR_LSB = 2;
  localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
  localparam logic TRACE_ON_RESET = 1'b0;
  // smallest buffer is 128 bytes: 2^7
  localparam int SIZE_BASE_LOG2 = 7;
  localparam logic [PTR_W-1:0] EVENT_BYTES = 24'h000008;
  // pointer reset value is undefined in hardware; this is a plain default
  localparam logic [PTR_W-1:0] PTR_RESET = 24'h000000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } ptb_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ptb_apb_rsp_s;

  typedef struct packed {
    logic valid;
    logic [PTR_W-1:0] addr;
    logic [63:0] data;
  } ptb_store_s;
endpackage

`default_nettype wire

// [src/ptb_trace_ctrl.sv]
/*
  program-counter trace buffer control: control and pointer registers on
  apb, and the store request that writes each trace event to memory.
  assumes the memory side accepts a store with store_ready and that
  trace events hold event_valid until event_ready on the system clock.
*/
// The implementer's own choice: the APB register port.
`default_nettype none

module ptb_trace_ctrl (
  input wire logic clk,
  input wire logic reset,
  input wire ptb_pkg::ptb_apb_req_s apb_req,
  output ptb_pkg::ptb_apb_rsp_s apb_rsp,
  input wire logic event_valid,
  input wire logic [63:0] event_data,
  output logic event_ready,
  output ptb_pkg::ptb_store_s store,
  input wire logic store_ready,
  output logic trace_on
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_STORE} ptb_state_e;

  ptb_state_e state_r, state_nxt;
  logic trace_on_r;
  logic [ptb_pkg::SEL_W-1:0] size_sel_r;
  logic [ptb_pkg::PTR_W-1:ptb_pkg::PTR_LSB] ptr_r, ptr_nxt;
  logic [ptb_pkg::PTR_W-1:0] store_addr_r;
  logic [63:0] store_data_r;
  logic [31:0] prdata_r;

  // wrap mask: ones over the offset bits inside the selected buffer
  function automatic logic [ptb_pkg::PTR_W-1:0] size_mask(
    input logic [ptb_pkg::SEL_W-1:0] sel
  );
    logic [ptb_pkg::PTR_W-1:0] one;
    one = 24'h000001;
    size_mask = (one << (ptb_pkg::SIZE_BASE_LOG2 + int'(sel))) - one;
  endfunction

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire logic access = apb_req.psel & apb_req.penable;
  wire logic wr = access & apb_req.pwrite;
  wire logic hit_ctrl = apb_req.paddr == ptb_pkg::CTRL_ADDR;
  wire logic hit_ptr = apb_req.paddr == ptb_pkg::PTR_ADDR;
  wire logic unmapped = ~(hit_ctrl | hit_ptr);
  wire logic wr_ctrl = wr & hit_ctrl;
  wire logic wr_ptr = wr & hit_ptr;
  wire logic [31:0] ctrl_view = {24'h000000, trace_on_r, 4'h0, size_sel_r};
  wire logic [31:0] ptr_view = {8'h00, ptr_r, 2'h0};
  wire logic [31:0] rd_mux = hit_ctrl ? ctrl_view : (hit_ptr ? ptr_view : 32'h00000000);

  // zero-wait slave; unmapped addresses answer with pslverr
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = access & unmapped;
  assign apb_rsp.prdata = prdata_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_r <= 32'h00000000;
    end else if (apb_req.psel & ~apb_req.penable & ~apb_req.pwrite) begin
      prdata_r <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      trace_on_r <= ptb_pkg::TRACE_ON_RESET;
      size_sel_r <= ptb_pkg::SEL_RESET;
    end else if (wr_ctrl) begin
      trace_on_r <= apb_req.pwdata[ptb_pkg::CTRL_ON_BIT];
      size_sel_r <= apb_req.pwdata[ptb_pkg::CTRL_SEL_LSB +: ptb_pkg::SEL_W];
    end
  end

  assign trace_on = trace_on_r;

  // ----------------------------------------------------------------
  // event capture and store
  // ----------------------------------------------------------------
  // one event in flight: new events wait on event_ready rather than queue
  wire logic take = event_valid & event_ready;
  assign event_ready = trace_on_r & (state_r == ST_IDLE);

  wire logic [ptb_pkg::PTR_W-1:0] cur_ptr = {ptr_r, 2'h0};
  wire logic [ptb_pkg::PTR_W-1:0] wmask = size_mask(size_sel_r);
  wire logic [ptb_pkg::PTR_W-1:0] inc_ptr = cur_ptr + ptb_pkg::EVENT_BYTES;
  wire logic [ptb_pkg::PTR_W-1:0] wrap_ptr = (cur_ptr & ~wmask) | (inc_ptr & wmask);
  wire logic store_done = (state_r == ST_STORE) & store_ready;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (take) begin
          state_nxt = ST_STORE;
        end
      end
      ST_STORE: begin
        if (store_ready) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // a software write to the pointer wins over the advance it collides with
  always_comb begin
    ptr_nxt = ptr_r;
    if (wr_ptr) begin
      ptr_nxt = apb_req.pwdata[ptb_pkg::PTR_W-1:ptb_pkg::PTR_LSB];
    end else if (store_done) begin
      ptr_nxt = wrap_ptr[ptb_pkg::PTR_W-1:ptb_pkg::PTR_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      ptr_r <= ptb_pkg::PTR_RESET[ptb_pkg::PTR_W-1:ptb_pkg::PTR_LSB];
    end else begin
      state_r <= state_nxt;
      ptr_r <= ptr_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      store_addr_r <= 24'h000000;
      store_data_r <= 64'h0000000000000000;
    end else if (take) begin
      store_addr_r <= cur_ptr;
      store_data_r <= event_data;
    end
  end

  assign store.valid = state_r == ST_STORE;
  assign store.addr = store_addr_r;
  assign store.data = store_data_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  enable_gates_a: assert property (event_ready |-> trace_on_r)
    else $error("event accepted while tracing is off");
  reset_values_a: assert property ($past(reset) |-> !trace_on_r && size_sel_r == 3'h0)
    else $error("control register not cleared by reset");
  size_write_a: assert property (wr_ctrl |=> size_sel_r == $past(apb_req.pwdata[2:0]))
    else $error("size select not written");
  ctrl_reserved_a: assert property (ctrl_view[6:3] == 4'h0)
    else $error("reserved control bits not zero");
  ptr_write_a: assert property (wr_ptr |=> ptr_view[23:2] == $past(apb_req.pwdata[23:2]))
    else $error("pointer write lost");
  ptr_align_a: assert property (store.valid |-> store.addr[1:0] == 2'h0)
    else $error("store address not word aligned");
  ptr_top_a: assert property (ptr_view[31:24] == 8'h00)
    else $error("pointer top byte not zero");
  ptr_advance_a: assert property (store_done && !wr_ptr |=>
      ({ptr_r, 2'h0} & wmask) == ((($past(cur_ptr) + 24'h000008)) & wmask)
      && ({ptr_r, 2'h0} & ~wmask) == ($past(cur_ptr) & ~wmask))
    else $error("pointer did not advance by eight within window");
  store_hold_a: assert property (store.valid && !store_ready |=> store.valid && $stable(store.addr))
    else $error("store request dropped before acceptance");

  // ----------------------------------------------------------------
  // bus side checks
  // ----------------------------------------------------------------
  bus_ready_a: assert property (apb_req.psel |-> apb_rsp.pready)
    else $error("slave not ready in a transfer");
  unmapped_err_a: assert property (access && unmapped |-> apb_rsp.pslverr)
    else $error("unmapped access without error");
  ctrl_read_a: assert property (
      apb_req.psel && !apb_req.penable && !apb_req.pwrite && hit_ctrl
      |=> apb_rsp.prdata[6:3] == 4'h0 && apb_rsp.prdata[31:8] == 24'h000000)
    else $error("control read shows reserved bits");
  ptr_read_a: assert property (
      apb_req.psel && !apb_req.penable && !apb_req.pwrite && hit_ptr
      |=> apb_rsp.prdata[1:0] == 2'h0 && apb_rsp.prdata[31:24] == 8'h00)
    else $error("pointer read shows reserved bits");
  enable_write_a: assert property (wr_ctrl |=> trace_on_r == $past(apb_req.pwdata[7]))
    else $error("enable bit not written");
  reserved_write_a: assert property (wr_ctrl |=> ctrl_view[6:3] == 4'h0)
    else $error("reserved control bits took write data");

  // ----------------------------------------------------------------
  // store side checks
  // ----------------------------------------------------------------
  off_no_take_a: assert property (!trace_on_r |-> !take)
    else $error("event taken while tracing is off");
  busy_no_ready_a: assert property (state_r == ST_STORE |-> !event_ready)
    else $error("second event offered while a store is pending");
  store_follows_a: assert property (take |=> store.valid)
    else $error("no store after an accepted event");
  store_addr_a: assert property (take |=> store.addr == $past(cur_ptr))
    else $error("store address is not the pointer");
  store_data_a: assert property (take |=> store.data == $past(event_data))
    else $error("store data is not the event");
  store_release_a: assert property (store_done |=> !store.valid)
    else $error("store held after acceptance");
  ptr_hold_a: assert property (!store_done && !wr_ptr |=> $stable(ptr_r))
    else $error("pointer moved with no store and no write");
  wrap_base_a: assert property (
      store_done && !wr_ptr && (cur_ptr & wmask) == (wmask & ~24'h000007)
      |=> ({ptr_r, 2'h0} & wmask) == 24'h000000)
    else $error("pointer did not wrap to the window base");

  // ----------------------------------------------------------------
  // shadow pointer and pending count
  // ----------------------------------------------------------------
  // an independent model of the pointer: the window is worked out from the
  // byte size directly rather than through the wrap mask function
  logic [ptb_pkg::PTR_W-1:0] chk_ptr_r;
  logic [1:0] chk_pend_r;
  wire logic [ptb_pkg::PTR_W-1:0] chk_win = 24'h000080 << size_sel_r;
  wire logic [ptb_pkg::PTR_W-1:0] chk_base = chk_ptr_r & ~(chk_win - 24'h000001);
  wire logic [ptb_pkg::PTR_W-1:0] chk_off = chk_ptr_r - chk_base + 24'h000008;
  wire logic [ptb_pkg::PTR_W-1:0] chk_next = (chk_off == chk_win) ? chk_base :
      chk_base + chk_off;

  always_ff @(posedge clk) begin
    if (reset) begin
      chk_ptr_r <= ptb_pkg::PTR_RESET;
    end else if (wr_ptr) begin
      chk_ptr_r <= {apb_req.pwdata[ptb_pkg::PTR_W-1:ptb_pkg::PTR_LSB], 2'h0};
    end else if (store_done) begin
      chk_ptr_r <= chk_next;
    end
  end

  // events taken minus stores accepted; more than one would mean a lost store
  always_ff @(posedge clk) begin
    if (reset) begin
      chk_pend_r <= 2'h0;
    end else if (take && !store_done) begin
      chk_pend_r <= chk_pend_r + 2'h1;
    end else if (store_done && !take) begin
      chk_pend_r <= chk_pend_r - 2'h1;
    end
  end

  shadow_ptr_a: assert property (cur_ptr == chk_ptr_r)
    else $error("pointer differs from its shadow");
  pend_bound_a: assert property (chk_pend_r <= 2'h1)
    else $error("more than one event in flight");
  pend_valid_a: assert property (store.valid == (chk_pend_r == 2'h1))
    else $error("store request does not match events in flight");

  event_store_c: cover property (take ##[1:4] store_done);
  wrap_c: cover property (store_done && ((cur_ptr & wmask) == (wmask & ~24'h000007)));
  ptr_write_c: cover property (wr_ptr ##1 take);
  stall_c: cover property (store.valid && !store_ready ##1 store_done);
  unmapped_c: cover property (access && unmapped);

endmodule // ptb_trace_ctrl

`default_nettype wire

// [verif/ptb_mem_model.sv]
/* memory model that takes trace stores from the trace control block.
   assumes a store holds valid, addr and data until store_ready at an edge. */
`default_nettype none
module ptb_mem_model (
  input wire logic clk,
  input wire ptb_pkg::ptb_store_s store,
  input wire logic [3:0] delay,
  output logic store_ready,
  output logic [23:0] last_addr,
  output logic [63:0] last_data,
  output logic [7:0] taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] held;
  // a slow memory keeps the request pending for delay cycles
  assign store_ready = store.valid && held >= delay;
  initial taken = 8'h00;
  initial held = 4'h0;
  always @(posedge clk) begin
    if (!store.valid || store_ready)
      held <= 4'h0;
    else
      held <= held + 4'h1;
    if (store_ready) begin
      last_addr <= store.addr;
      last_data <= store.data;
      taken <= taken + 8'h01;
    end
  end
endmodule // ptb_mem_model
`default_nettype wire

// [verif/tb_top.sv]
/* self-checking bench for the trace control block: apb registers, stores.
   assumes zero or more apb wait states and the memory model beside it. */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [25:0] a; logic [31:0] d; logic [31:0] e; logic err;} ptb_row_s;
  logic clk, reset, event_valid, event_ready, store_ready, trace_on, er;
  logic [63:0] event_data, ld;
  logic [31:0] rd;
  logic [23:0] la, base, sz;
  logic [7:0] taken, t0;
  logic [3:0] delay;
  ptb_pkg::ptb_apb_req_s req;
  ptb_pkg::ptb_apb_rsp_s rsp;
  ptb_pkg::ptb_store_s store;
  int failures, samples_checked, cycles;
  ptb_row_s rows[5] = '{
    '{ptb_pkg::CTRL_ADDR, 32'hffffffff, 32'h00000087, 1'b0},
    '{ptb_pkg::CTRL_ADDR, 32'h00000005, 32'h00000005, 1'b0},
    '{ptb_pkg::PTR_ADDR, 32'hffffffff, 32'h00fffffc, 1'b0},
    '{ptb_pkg::PTR_ADDR, 32'h00123457, 32'h00123454, 1'b0},
    '{26'h0000010, 32'h00000001, 32'h00000000, 1'b1}};
  ptb_trace_ctrl dut (.clk(clk), .reset(reset), .apb_req(req), .apb_rsp(rsp),
    .event_valid(event_valid), .event_data(event_data), .event_ready(event_ready),
    .store(store), .store_ready(store_ready), .trace_on(trace_on));
  ptb_mem_model mem (.clk(clk), .store(store), .delay(delay), .store_ready(store_ready),
    .last_addr(la), .last_data(ld), .taken(taken));
  always #2.5 clk = ~clk;
  task automatic finish_test();
    if (failures == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [25:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
  endtask
  task automatic send_event(input logic [63:0] d);
    t0 = taken;
    event_valid <= 1'b1;
    event_data <= d;
    do @(posedge clk); while (event_ready !== 1'b1);
    event_valid <= 1'b0;
    do @(posedge clk); while (taken == t0);
  endtask
  initial begin
    clk = 0;
    reset = 1;
    req = '0;
    event_valid = 0;
    event_data = 64'h0;
    delay = 4'h0;
    repeat (3) @(posedge clk);
    reset <= 0;
    apb(0, ptb_pkg::CTRL_ADDR, 32'h0);
    check(rd, 32'h0);
    foreach (rows[i]) begin
      apb(1, rows[i].a, rows[i].d);
      apb(0, rows[i].a, 32'h0);
      check({er, rd}, {rows[i].err, rows[i].e});
    end
    base = 24'h400000;
    for (int s = 0; s < 8; s++) begin
      sz = 24'h000080 << s;
      delay <= (s == 0) ? 4'h5 : 4'h0;
      apb(1, ptb_pkg::PTR_ADDR, {8'h00, base + sz - 24'h8});
      apb(1, ptb_pkg::CTRL_ADDR, 32'h80 | s);
      @(posedge clk);
      check(trace_on, 1'b1);
      send_event({32'hc0de0000, s});
      check(la, base + sz - 24'h8);
      check(ld, {32'hc0de0000, s});
      send_event(64'h1234);
      check(la, base);
      apb(0, ptb_pkg::PTR_ADDR, 32'h0);
      check(rd, {8'h00, base + 24'h8});
    end
    apb(1, ptb_pkg::CTRL_ADDR, 32'h3);
    t0 = taken;
    event_valid <= 1'b1;
    repeat (4) @(posedge clk);
    check({event_ready, taken}, {1'b0, t0});
    event_valid <= 1'b0;
    reset <= 1;
    repeat (3) @(posedge clk);
    reset <= 0;
    apb(0, ptb_pkg::CTRL_ADDR, 32'h0);
    check({trace_on, rd}, 33'h0);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
